// ---- core/cpu_strobe.sv ----
// cpu bus strobe decode, holding registers and receive error flags
module cpu_strobe (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic chip_select_high_a,
   input wire logic chip_select_low_b,
   input wire logic chip_select_high_c,
   input wire logic read_not_write,
   input wire logic bus_timing_pulse,
   input wire logic register_select,
   input wire logic [cpu_strobe_pkg::DATA_W-1:0] bus_data_in,
   input wire logic device_clock,
   input wire logic serial_in,
   input wire logic rx_word_valid,
   input wire logic [cpu_strobe_pkg::DATA_W-1:0] rx_word,
   input wire logic rx_parity_bad,
   input wire logic rx_frame_bad,
   input wire logic tx_holding_taken,
   output logic [cpu_strobe_pkg::DATA_W-1:0] bus_data_out,
   output logic bus_data_oe_n,
   output logic data_available_flag,
   output logic overrun_parity_error,
   output logic [cpu_strobe_pkg::DATA_W-1:0] tx_holding,
   output logic tx_holding_load,
   output logic [cpu_strobe_pkg::DATA_W-1:0] ctrl_reg,
   output logic start_seen
);
   import cpu_strobe_pkg::*;

   function automatic logic sel_ok(input logic a, input logic b,
                                   input logic c);
      sel_ok = a & ~b & c;
   endfunction

   // ----------------------------------------
   // strobe decode
   // ----------------------------------------
   logic rd_now;
   logic wr_now;
   logic wr_q;
   logic wr_d;
   logic sel_q;
   logic sel_d;
   logic rd_q;
   logic rd_d;
   logic [DATA_W-1:0] data_q;
   logic [DATA_W-1:0] data_d;
   always_comb begin
      rd_now = sel_ok(chip_select_high_a, chip_select_low_b,
                      chip_select_high_c) & read_not_write;
      wr_now = sel_ok(chip_select_high_a, chip_select_low_b,
                      chip_select_high_c) & ~read_not_write
               & bus_timing_pulse;
      wr_d = wr_now;
      rd_d = rd_now;
      // select and data follow the strobe so the trailing edge sees them
      sel_d = wr_now ? register_select : sel_q;
      data_d = wr_now ? bus_data_in : data_q;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_q <= 1'h0;
         rd_q <= 1'h0;
         sel_q <= SEL_DATA;
         data_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         sel_q <= sel_d;
         data_q <= data_d;
      end
   end

   // ----------------------------------------
   // receive side flags
   // ----------------------------------------
   logic [DATA_W-1:0] rhr_q;
   logic [DATA_W-1:0] rhr_d;
   logic da_q;
   logic da_d;
   logic oe_q;
   logic oe_d;
   logic pe_q;
   logic pe_d;
   logic fe_q;
   logic fe_d;
   logic opp_q;
   logic opp_d;
   logic rd_end;
   always_comb begin
      // only a read of the data register takes the pending word
      rd_end = rd_q & ~rd_now & (register_select == SEL_DATA);
      rhr_d = rhr_q;
      da_d = da_q;
      oe_d = oe_q;
      pe_d = pe_q;
      fe_d = fe_q;
      if (rd_end)
         da_d = 1'h0;
      if (rx_word_valid) begin
         rhr_d = rx_word;
         // a read ending in the same cycle still counts as taken
         oe_d = da_q & ~rd_end;
         da_d = 1'h1;
         pe_d = rx_parity_bad;
         fe_d = rx_frame_bad;
      end
      // shared pin registered so the output comes from a flop
      opp_d = oe_d | pe_d;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rhr_q <= '0;
         da_q <= 1'h0;
         oe_q <= 1'h0;
         pe_q <= 1'h0;
         fe_q <= 1'h0;
         opp_q <= 1'h0;
      end else begin
         rhr_q <= rhr_d;
         da_q <= da_d;
         oe_q <= oe_d;
         pe_q <= pe_d;
         fe_q <= fe_d;
         opp_q <= opp_d;
      end
   end

   // ----------------------------------------
   // transmit holding and control register
   // ----------------------------------------
   logic [DATA_W-1:0] thr_q;
   logic [DATA_W-1:0] thr_d;
   logic [DATA_W-1:0] ctrl_q;
   logic [DATA_W-1:0] ctrl_d;
   logic thre_q;
   logic thre_d;
   logic ld_q;
   logic ld_d;
   always_comb begin
      thr_d = thr_q;
      ctrl_d = ctrl_q;
      thre_d = thre_q | tx_holding_taken;
      ld_d = 1'h0;
      if (wr_q & ~wr_now) begin // trailing edge
         if (sel_q == SEL_DATA) begin
            thr_d = data_q;
            thre_d = 1'h0;
            ld_d = 1'h1;
         end else begin
            ctrl_d = data_q;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         thr_q <= '0;
         ctrl_q <= CTRL_RESET;
         thre_q <= STATUS_RESET[ST_THRE];
         ld_q <= 1'h0;
      end else begin
         thr_q <= thr_d;
         ctrl_q <= ctrl_d;
         thre_q <= thre_d;
         ld_q <= ld_d;
      end
   end

   // ----------------------------------------
   // start bit catch on device clock fall
   // ----------------------------------------
   rx_state_type st_q;
   rx_state_type st_d;
   logic dclk_q;
   logic si_q;
   logic start_q;
   logic start_d;
   always_comb begin
      st_d = st_q;
      start_d = 1'h0;
      // a start landing just before a fall is simply seen at the next fall
      case (st_q)
         rx_idle_type_s: if (~si_q) st_d = rx_armed_type_s;
         rx_armed_type_s: begin
            if (si_q)
               st_d = rx_idle_type_s;
            else if (dclk_q & ~device_clock) begin
               st_d = rx_busy_type_s;
               start_d = 1'h1;
            end
         end
         rx_busy_type_s: if (rx_word_valid) st_d = rx_idle_type_s;
         default: st_d = rx_idle_type_s;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= rx_idle_type_s;
         dclk_q <= 1'h0;
         si_q <= 1'h1;
         start_q <= 1'h0;
      end else begin
         st_q <= st_d;
         dclk_q <= device_clock;
         si_q <= serial_in;
         start_q <= start_d;
      end
   end

   // ----------------------------------------
   // read data and outputs
   // ----------------------------------------
   logic [DATA_W-1:0] out_q;
   logic [DATA_W-1:0] out_d;
   logic oen_q;
   logic oen_d;
   always_comb begin
      out_d = (register_select == SEL_DATA) ? rhr_q :
              {thre_q, 3'h0, fe_q, pe_q, oe_q, da_q};
      oen_d = ~rd_now;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_q <= '0;
         oen_q <= 1'h1;
      end else begin
         out_q <= out_d;
         oen_q <= oen_d;
      end
   end

   always_comb begin
      bus_data_out = out_q;
      bus_data_oe_n = oen_q;
      data_available_flag = da_q;
      overrun_parity_error = opp_q;
      tx_holding = thr_q;
      tx_holding_load = ld_q;
      ctrl_reg = ctrl_q;
      start_seen = start_q;
   end
endmodule

// ---- core/cpu_strobe_pkg.sv ----
// constants and state types for the cpu bus strobe block
// What this block does
// - start bit accepted asynchronously, next falling edge
// - read needs selects a,c high, b low, dir high
// - overrun set when new word lands unread
// - overrun or parity on shared pin, separate bits
// - write needs timing pulse, selects, dir low
// - transmit holding loaded at pulse trailing edge
// - data available set when word received
package cpu_strobe_pkg;
   localparam int DATA_W = 8;
   // register select values
   localparam logic SEL_DATA = 1'h0;
   localparam logic SEL_CTRL = 1'h1;
   // status register field positions
   localparam int ST_DA = 0;
   localparam int ST_OE = 1;
   localparam int ST_PE = 2;
   localparam int ST_FE = 3;
   localparam int ST_THRE = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h80;
   typedef enum logic [1:0] {
      rx_idle_type_s,
      rx_armed_type_s,
      rx_busy_type_s
   } rx_state_type;
endpackage

// ---- dv/cpu_bus_host.sv ----
// cpu side bus master model, one strobed access per call
module cpu_bus_host (
   input wire logic clk_sys, bus_data_oe_n,
   input wire logic [7:0] bus_data_out,
   output logic chip_select_high_a = 1'h0, chip_select_low_b = 1'h1,
   output logic chip_select_high_c = 1'h0, read_not_write = 1'h1,
   output logic bus_timing_pulse = 1'h0, register_select = 1'h0,
   output logic [7:0] bus_data_in = 8'h00
);
   timeunit 1ns / 1ns;
   task automatic access(input logic s, r, ok, input logic [7:0] d,
         output logic [7:0] q);
      int n = 0;
      @(posedge clk_sys) #1;
      {chip_select_high_a, chip_select_low_b, chip_select_high_c} = {ok, 2'h1};
      {read_not_write, register_select, bus_data_in} = {r, s, d};
      bus_timing_pulse = ~r;
      @(posedge clk_sys) #1 bus_timing_pulse = 1'h0;
      do @(posedge clk_sys) #1;
      while (r && bus_data_oe_n !== 1'h0 && ++n < 8);
      if (!r) @(posedge clk_sys) #1;
      q = n < 8 ? bus_data_out : 8'hXX;
      // released data lines show the inverse, never the stale value
      #1 {chip_select_high_a, chip_select_low_b, chip_select_high_c} = 3'h2;
      bus_data_in = ~d;
   endtask
endmodule

// ---- dv/cpu_strobe_asserts.sv ----
// port assertions for the cpu bus strobe block
module cpu_strobe_asserts (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic chip_select_high_a,
   input wire logic chip_select_low_b,
   input wire logic chip_select_high_c,
   input wire logic read_not_write,
   input wire logic bus_timing_pulse,
   input wire logic register_select,
   input wire logic device_clock,
   input wire logic rx_word_valid,
   input wire logic bus_data_oe_n,
   input wire logic data_available_flag,
   input wire logic tx_holding_load,
   input wire logic overrun_parity_error,
   input wire logic start_seen
);
   wire s = chip_select_high_a & ~chip_select_low_b & chip_select_high_c;
   wire rd = s & read_not_write;
   wire wr = s & ~read_not_write & bus_timing_pulse;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_read_drive: assert property (rd |=> !bus_data_oe_n)
      else $error("read not driven");
   chk_bus_release: assert property (!rd ##1 !rd |=> bus_data_oe_n)
      else $error("bus not released");
   chk_write_load: assert property (wr && !register_select ##1
      !bus_timing_pulse |=> tx_holding_load) else $error("no load");
   chk_ctrl_noload: assert property (wr && register_select ##1
      !bus_timing_pulse |=> !tx_holding_load) else $error("stray load");
   chk_load_cause: assert property
      (tx_holding_load |-> $past(wr, 2) && !$past(wr)) else $error("bad load");
   chk_overrun_set: assert property (rx_word_valid &&
      data_available_flag && !rd && !$past(rd) |=> overrun_parity_error)
      else $error("overrun missed");
   chk_da_set: assert property (rx_word_valid |=> data_available_flag)
      else $error("flag not set");
   chk_start_fall: assert property (start_seen |-> !device_clock)
      else $error("start off edge");
endmodule
bind cpu_strobe cpu_strobe_asserts chk (.*);

// ---- dv/testbench.sv ----
// self-checking bench for the cpu bus strobe block
module testbench;
   timeunit 1ns / 1ns;
   logic clk_sys = 1'h0, rst = 1'h1, device_clock = 1'h0, serial_in = 1'h1;
   logic rx_word_valid = 1'h0, rx_parity_bad = 1'h0, tx_holding_taken = 1'h0;
   logic chip_select_high_a, chip_select_low_b, chip_select_high_c, start_seen;
   logic read_not_write, bus_timing_pulse, register_select, bus_data_oe_n;
   logic data_available_flag, overrun_parity_error, tx_holding_load;
   logic [7:0] bus_data_in, bus_data_out, tx_holding, ctrl_reg, q;
   logic [7:0] rx_word = 8'h00;
   logic rx_frame_bad = 1'h0;
   int error_cnt = 0, num_checks = 0, loads = 0;
   cpu_bus_host host (.*);
   cpu_strobe dut (.*);
   always @(posedge clk_sys) if (tx_holding_load === 1'h1) loads++;
   initial forever #25 clk_sys = ~clk_sys;
   initial forever #200 device_clock = ~device_clock;
   task automatic chk(input string n, input logic [7:0] s, e);
      num_checks++;
      if (s !== e) error_cnt++;
      if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic word(input logic [7:0] w, input logic p, f);
      @(posedge clk_sys) #1;
      {tx_holding_taken, rx_word_valid, rx_parity_bad} = {2'h3, p};
      {rx_frame_bad, rx_word} = {f, w};
      @(posedge clk_sys) #1 {tx_holding_taken, rx_word_valid} = 2'h0;
   endtask
   task automatic t_write();
      host.access(1'h0, 1'h0, 1'h1, 8'hA5, q);
      chk("holding", tx_holding, 8'hA5);
      host.access(1'h0, 1'h0, 1'h0, 8'h3C, q);
      chk("refused", tx_holding, 8'hA5);
      host.access(1'h1, 1'h0, 1'h1, 8'h5A, q);
      chk("control", ctrl_reg, 8'h5A);
      chk("load count", loads[7:0], 8'h01);
   endtask
   task automatic t_rx();
      word(8'h96, 1'h0, 1'h0);
      chk("flag", data_available_flag, 8'h01);
      word(8'h69, 1'h0, 1'h0);
      chk("overrun pin", overrun_parity_error, 8'h01);
      host.access(1'h1, 1'h1, 1'h1, 8'h00, q);
      chk("status", q, 8'h83);
      host.access(1'h0, 1'h1, 1'h1, 8'h00, q);
      chk("data", q, 8'h69);
      @(posedge clk_sys) #1 chk("flag clear", data_available_flag, 8'h00);
      chk("released", bus_data_oe_n, 8'h01);
      word(8'h11, 1'h1, 1'h0);
      chk("parity pin", overrun_parity_error, 8'h01);
      host.access(1'h1, 1'h1, 1'h1, 8'h00, q);
      chk("status parity", q, 8'h85);
      host.access(1'h0, 1'h1, 1'h1, 8'h00, q);
      chk("data 2", q, 8'h11);
      word(8'h22, 1'h0, 1'h1);
      host.access(1'h1, 1'h1, 1'h1, 8'h00, q);
      chk("status frame", q, 8'h89);
   endtask
   task automatic t_start();
      int n = 0;
      serial_in = 1'h0;
      while (start_seen !== 1'h1 && ++n < 200) @(posedge clk_sys) #1;
      #1 serial_in = 1'h1;
      chk("start", n < 200, 8'h01);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      #1 rst = 1'h0;
      t_write();
      t_rx();
      t_start();
      tally_and_finish();
   end
endmodule
